// [chg_config_bank.sv]
`timescale 1ns/1ns
`include "chg_consts.svh"
// How it works
// (R1) Battery config bits 7-6 pick IR compensation 0/20/40/80 milliohm, reset 00.
// (R2) Battery config bits 5-3 pick one to six cells, reset one cell.
// (R3) Battery config bits 2-0 pick per-cell voltage 4.1 to 4.5 V, reset 4.2 V.
// (R4) Internal reference is upper byte joined with two top bits of next register.
// (R5) Ratio bit 0 picks bus voltage scale 12.5x or 5x.
// (R6) Fast-discharge level in bits 1-0 acts only in discharge mode, reset none.
// (R7) External reference is its upper byte joined with two top bits, reset 124/3.
// (R8) Bus current limit code resets to 255 and serves both directions.
// (R9) Battery current limit code resets to 255 and serves both directions.
// (R10) Input regulation code resets to 44 and sets the charging input reference.
// (R11) Input regulation scale bit picks 40x when set, 100x when clear.
// (R12) Battery current scale bit 4; bus current scale bits 3-2 only 01 or 10.
// (R13) Ratio bit 1 picks battery monitor scale 12.5x or 5x.
// (R14) Control zero bit 7 picks charge at 0 or discharge at 1.
// (R15) Host keeps reserved internal-use bits at their reset values.
// (R16) Feedback select bit picks internal or external reference, in charge and discharge alike.
// (R17) Result lower registers carry two low result bits in 7-6, rest zero.
// (R18) Writable registers keep the last host write until reset, save rejected ratio bits 3-2.
// (R19) Writes to read-only addresses do nothing; reserved addresses read zero.
module chg_config_bank #(
  parameter logic [6:0] DEV_ADDR = 7'h2a  // Arbitrary bus address
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Two-wire serial port
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // Converter results and event status
  input wire chg_pkg::chg_code_t bus_v_result_i,
  input wire chg_pkg::chg_code_t bat_v_result_i,
  input wire chg_pkg::chg_code_t bus_i_result_i,
  input wire chg_pkg::chg_code_t bat_i_result_i,
  input wire logic [7:1] status_i,
  // Battery settings
  output logic [1:0] ir_compensation_o,
  output logic [2:0] cell_count_select_o,
  output logic [2:0] per_cell_voltage_o,
  // Output references and fast-discharge level
  output chg_pkg::chg_code_t internal_ref_code_o,
  output chg_pkg::chg_code_t external_ref_code_o,
  output chg_pkg::chg_code_t active_ref_code_o,
  output logic [1:0] fast_discharge_level_o,
  // Limits and regulation
  output logic [7:0] bus_current_limit_code_o,
  output logic [7:0] battery_current_limit_code_o,
  output logic [7:0] input_regulation_code_o,
  output logic input_regulation_scale_o,
  // Scaling ratios
  output logic battery_current_scale_o,
  output logic [1:0] bus_current_scale_o,
  output logic battery_monitor_scale_o,
  output logic bus_voltage_scale_o,
  // Modes
  output logic discharge_direction_select_o,
  output logic feedback_source_select_o,
  // Raw control, mask and data-line registers
  output logic [7:0] control_zero_o,
  output logic [7:0] control_one_o,
  output logic [7:0] control_two_o,
  output logic [7:0] control_three_o,
  output logic [7:0] event_mask_o,
  output logic [7:0] data_line_control_o,
  output logic [7:0] data_line_readback_o
);
  import chg_pkg::*;

  // ****************************************************************
  // State and reset image
  // ****************************************************************
  localparam chg_main_s RST = '{
    st: CHG_ST_IDLE,
    cnt: 4'h0,
    shift: 8'h00,
    ptr: 8'h00,
    rnw: 1'b0,
    first: 1'b0,
    nack: 1'b0,
    drive_low: 1'b0,
    rw: '{
      0: `CHG_RST_BATCFG,
      1: `CHG_RST_IREF_HI,
      2: `CHG_RST_IREF_LO,
      3: `CHG_RST_EREF_HI,
      4: `CHG_RST_EREF_LO,
      5: `CHG_RST_BUS_SIDE_CURRENT_LIM,
      6: `CHG_RST_BATTERY_SIDE_CURRENT_LIM,
      7: `CHG_RST_INPUT_REGULATION_VOLTAGE,
      8: `CHG_RST_RATIO,
      9: `CHG_RST_CTRL0,
      10: `CHG_RST_CTRL1,
      11: `CHG_RST_CTRL2,
      12: `CHG_RST_CTRL3,
      13: `CHG_RST_MASK,
      14: `CHG_RST_DLCTRL,
      15: `CHG_RST_DLRD
    }
  };

  chg_main_s q;
  chg_main_s d;
  logic wr_en;
  logic ld_rd;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [4:0] wr_slot;
  logic [1:0] bat_v_lo2;

  chg_line_if line ();

  chg_pin_sync u_sync (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .line(line)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Bit 4 flags a writable register, bits 3-0 give its slot
  function automatic logic [4:0] rw_slot(input logic [7:0] a);
    logic [4:0] r;
    r = 5'h00;
    if (a <= `CHG_OFF_CTRL3) begin
      r = {1'b1, a[3:0]};
    end else if (a == `CHG_OFF_MASK) begin
      r = {1'b1, `CHG_SLOT_MASK};
    end else if (a == `CHG_OFF_DLCTRL) begin
      r = {1'b1, `CHG_SLOT_DLCTRL};
    end else if (a == `CHG_OFF_DLRD) begin
      r = {1'b1, `CHG_SLOT_DLRD};
    end
    return r;
  endfunction : rw_slot

  function automatic chg_code_t join10(input logic [7:0] hi, input logic [7:0] lo);
    return {hi, lo[`CHG_POS_LOW2 +: 2]};
  endfunction : join10

  function automatic logic [7:0] reg_read(input logic [7:0] a);
    logic [4:0] s;
    logic [7:0] r;
    s = rw_slot(a);
    r = 8'h00;  // R19
    if (s[4]) begin
      r = q.rw[s[3:0]];
    end else begin
      unique case (a)
        `CHG_OFF_BUS_SIDE_VOLTAGE_HI: r = bus_v_result_i[9:2];
        `CHG_OFF_BUS_SIDE_VOLTAGE_LO: r = {bus_v_result_i[1:0], 6'h00};  // R17
        `CHG_OFF_VBAT_HI: r = bat_v_result_i[9:2];
        `CHG_OFF_VBAT_LO: r = {bat_v_result_i[1:0], 6'h00};  // R17
        `CHG_OFF_BUS_SIDE_CURRENT_HI: r = bus_i_result_i[9:2];
        `CHG_OFF_BUS_SIDE_CURRENT_LO: r = {bus_i_result_i[1:0], 6'h00};  // R17
        `CHG_OFF_BATTERY_SIDE_CURRENT_HI: r = bat_i_result_i[9:2];
        `CHG_OFF_BATTERY_SIDE_CURRENT_LO: r = {bat_i_result_i[1:0], 6'h00};  // R17
        `CHG_OFF_STATUS: r = {status_i, 1'b0};
        default: r = 8'h00;  // R19
      endcase
    end
    return r;
  endfunction : reg_read

  // ****************************************************************
  // Serial protocol and register access
  // ****************************************************************
  always_comb begin
    d = q;
    wr_en = 1'b0;
    ld_rd = 1'b0;
    wr_addr = q.ptr;
    wr_data = q.shift;
    wr_slot = rw_slot(q.ptr);
    if (ce_i) begin
      if (line.start_det) begin
        d.st = CHG_ST_ADDR;
        d.cnt = 4'h0;
        d.first = 1'b1;
        d.drive_low = 1'b0;
      end else if (line.stop_det) begin
        d.st = CHG_ST_IDLE;
        d.drive_low = 1'b0;
      end else if (line.scl_rise) begin
        unique case (q.st)
          CHG_ST_ADDR, CHG_ST_WDATA: begin
            d.shift = {q.shift[6:0], line.sda};
            d.cnt = q.cnt + 4'h1;
          end
          CHG_ST_RDATA: d.cnt = q.cnt + 4'h1;
          CHG_ST_RACK: d.nack = line.sda;
          CHG_ST_IDLE, CHG_ST_ADDR_ACK, CHG_ST_WACK: ;
        endcase
      end else if (line.scl_fall) begin
        unique case (q.st)
          CHG_ST_ADDR: begin
            if (q.cnt == 4'h8) begin
              if (q.shift[7:1] == DEV_ADDR) begin
                d.st = CHG_ST_ADDR_ACK;
                d.rnw = q.shift[0];
                d.drive_low = 1'b1;
              end else begin
                d.st = CHG_ST_IDLE;
              end
            end
          end
          CHG_ST_ADDR_ACK: begin
            if (q.rnw) begin
              ld_rd = 1'b1;
            end else begin
              d.st = CHG_ST_WDATA;
              d.cnt = 4'h0;
              d.drive_low = 1'b0;
            end
          end
          CHG_ST_WDATA: begin
            if (q.cnt == 4'h8) begin
              d.st = CHG_ST_WACK;
              d.drive_low = 1'b1;
              if (q.first) begin
                d.ptr = q.shift;
              end else begin
                wr_en = 1'b1;
                d.ptr = q.ptr + 8'h01;
              end
            end
          end
          CHG_ST_WACK: begin
            d.st = CHG_ST_WDATA;
            d.cnt = 4'h0;
            d.first = 1'b0;
            d.drive_low = 1'b0;
          end
          CHG_ST_RDATA: begin
            if (q.cnt == 4'h8) begin
              d.st = CHG_ST_RACK;
              d.drive_low = 1'b0;
            end else begin
              d.shift = {q.shift[6:0], 1'b0};
              d.drive_low = ~q.shift[6];
            end
          end
          CHG_ST_RACK: begin
            if (q.nack) begin
              d.st = CHG_ST_IDLE;
            end else begin
              ld_rd = 1'b1;
            end
          end
          CHG_ST_IDLE: ;
        endcase
      end
    end
    // Read data is captured at the falling edge that opens its first bit
    if (ld_rd) begin
      d.shift = reg_read(q.ptr);
      d.ptr = q.ptr + 8'h01;
      d.st = CHG_ST_RDATA;
      d.cnt = 4'h0;
      d.drive_low = ~d.shift[7];
    end
    // Read-only and reserved addresses take no write
    if (wr_en && wr_slot[4]) begin  // R19
      d.rw[wr_slot[3:0]] = wr_data;  // R18
      if (wr_addr == `CHG_OFF_RATIO &&
          (wr_data[`CHG_POS_IBUSR +: 2] == `CHG_IBUSR_BAD_LO ||
           wr_data[`CHG_POS_IBUSR +: 2] == `CHG_IBUSR_BAD_HI)) begin
        d.rw[wr_slot[3:0]][`CHG_POS_IBUSR +: 2] = q.rw[8][`CHG_POS_IBUSR +: 2];  // R12
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~q.drive_low;
  assign bat_v_lo2 = bat_v_result_i[1:0];

  assign ir_compensation_o = q.rw[0][`CHG_POS_IRC +: 2];  // R1
  assign cell_count_select_o = q.rw[0][`CHG_POS_CELL_COUNT_SELECT +: 3];  // R2
  assign per_cell_voltage_o = q.rw[0][`CHG_POS_VCELL +: 3];  // R3
  assign internal_ref_code_o = join10(q.rw[1], q.rw[2]);  // R4
  assign external_ref_code_o = join10(q.rw[3], q.rw[4]);  // R7
  assign active_ref_code_o = feedback_source_select_o ?
                             external_ref_code_o : internal_ref_code_o;  // R16
  assign fast_discharge_level_o = discharge_direction_select_o ?
                                  q.rw[2][`CHG_POS_FD +: 2] : 2'b00;  // R6
  assign bus_current_limit_code_o = q.rw[5];  // R8
  assign battery_current_limit_code_o = q.rw[6];  // R9
  assign input_regulation_code_o = q.rw[7];  // R10
  assign input_regulation_scale_o = q.rw[9][`CHG_POS_VINR];  // R11
  assign battery_current_scale_o = q.rw[8][`CHG_POS_IBATR];  // R12
  assign bus_current_scale_o = q.rw[8][`CHG_POS_IBUSR +: 2];  // R12
  assign battery_monitor_scale_o = q.rw[8][`CHG_POS_VBATMON];  // R13
  assign bus_voltage_scale_o = q.rw[8][`CHG_POS_VBUSR];  // R5
  assign discharge_direction_select_o = q.rw[9][`CHG_POS_OTG];  // R14
  assign feedback_source_select_o = q.rw[10][`CHG_POS_FB];  // R16
  assign control_zero_o = q.rw[9];
  assign control_one_o = q.rw[10];
  assign control_two_o = q.rw[11];
  assign control_three_o = q.rw[12];
  assign event_mask_o = q.rw[`CHG_SLOT_MASK];
  assign data_line_control_o = q.rw[`CHG_SLOT_DLCTRL];
  assign data_line_readback_o = q.rw[`CHG_SLOT_DLRD];

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  a_cfg_write_kept: assert property (  // R18
    (wr_en && wr_slot[4] && wr_addr != `CHG_OFF_RATIO) |=>
      reg_read($past(wr_addr)) == $past(wr_data))
    else $error("written register does not read back");

  a_ro_write_ignored: assert property (  // R19
    (wr_en && !wr_slot[4]) |=> $stable(q.rw))
    else $error("write to read-only address changed storage");

  a_rsvd_read_zero: assert property (  // R19
    (ld_rd && (q.ptr == `CHG_OFF_RSVD_A || q.ptr == `CHG_OFF_RSVD_C)) |=>
      q.shift == 8'h00)
    else $error("reserved address read nonzero");

  a_result_low_split: assert property (  // R17
    (ld_rd && q.ptr == `CHG_OFF_VBAT_LO) |=>
      q.shift == {$past(bat_v_lo2), 6'h00})
    else $error("result lower register layout wrong");

  a_int_ref_upper: assert property (  // R4
    (wr_en && wr_addr == `CHG_OFF_IREF_HI) |=>
      internal_ref_code_o[9:2] == $past(wr_data) ##1 $stable(internal_ref_code_o))
    else $error("internal reference upper byte not taken");

  a_fd_charge_zero: assert property (  // R6
    !discharge_direction_select_o |-> fast_discharge_level_o == 2'b00)
    else $error("fast discharge active while charging");

  a_fb_select_ext: assert property (  // R16
    (feedback_source_select_o && $stable(q.rw)) |->
      active_ref_code_o == join10(q.rw[3], q.rw[4]))
    else $error("external reference not selected");

  a_bus_ratio_legal: assert property (  // R12
    bus_current_scale_o != `CHG_IBUSR_BAD_LO && bus_current_scale_o != `CHG_IBUSR_BAD_HI)
    else $error("illegal bus current scale held");

  a_dir_write: assert property (  // R14
    (wr_en && wr_addr == `CHG_OFF_CTRL0) |=>
      discharge_direction_select_o == $past(wr_data[`CHG_POS_OTG]))
    else $error("direction select not taken");

endmodule : chg_config_bank

// [chg_consts.svh]
`ifndef CHG_CONSTS_SVH
`define CHG_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CHG_OFF_BATCFG 8'h00
`define CHG_OFF_IREF_HI 8'h01
`define CHG_OFF_IREF_LO 8'h02
`define CHG_OFF_EREF_HI 8'h03
`define CHG_OFF_EREF_LO 8'h04
`define CHG_OFF_BUS_SIDE_CURRENT_LIM 8'h05
`define CHG_OFF_BATTERY_SIDE_CURRENT_LIM 8'h06
`define CHG_OFF_INPUT_REGULATION_VOLTAGE 8'h07
`define CHG_OFF_RATIO 8'h08
`define CHG_OFF_CTRL0 8'h09
`define CHG_OFF_CTRL1 8'h0a
`define CHG_OFF_CTRL2 8'h0b
`define CHG_OFF_CTRL3 8'h0c
`define CHG_OFF_BUS_SIDE_VOLTAGE_HI 8'h0d
`define CHG_OFF_BUS_SIDE_VOLTAGE_LO 8'h0e
`define CHG_OFF_VBAT_HI 8'h0f
`define CHG_OFF_VBAT_LO 8'h10
`define CHG_OFF_BUS_SIDE_CURRENT_HI 8'h11
`define CHG_OFF_BUS_SIDE_CURRENT_LO 8'h12
`define CHG_OFF_BATTERY_SIDE_CURRENT_HI 8'h13
`define CHG_OFF_BATTERY_SIDE_CURRENT_LO 8'h14
`define CHG_OFF_RSVD_A 8'h15
`define CHG_OFF_RSVD_B 8'h16
`define CHG_OFF_STATUS 8'h17
`define CHG_OFF_RSVD_C 8'h18
`define CHG_OFF_MASK 8'h19
`define CHG_OFF_DLCTRL 8'h1a
`define CHG_OFF_DLRD 8'h1b

// ****************************************************************
// Storage slots of the registers above the control block
// ****************************************************************
`define CHG_SLOT_MASK 4'hd
`define CHG_SLOT_DLCTRL 4'he
`define CHG_SLOT_DLRD 4'hf

// ****************************************************************
// Reset values
// ****************************************************************
`define CHG_RST_BATCFG 8'h01
`define CHG_RST_IREF_HI 8'h31
`define CHG_RST_IREF_LO 8'hc0
`define CHG_RST_EREF_HI 8'h7c
`define CHG_RST_EREF_LO 8'hc0
`define CHG_RST_BUS_SIDE_CURRENT_LIM 8'hff
`define CHG_RST_BATTERY_SIDE_CURRENT_LIM 8'hff
`define CHG_RST_INPUT_REGULATION_VOLTAGE 8'h2c
`define CHG_RST_RATIO 8'h38
`define CHG_RST_CTRL0 8'h04
`define CHG_RST_CTRL1 8'h01
`define CHG_RST_CTRL2 8'h01
`define CHG_RST_CTRL3 8'h02
`define CHG_RST_MASK 8'h80
`define CHG_RST_DLCTRL 8'h00
`define CHG_RST_DLRD 8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define CHG_POS_IRC 6
`define CHG_POS_CELL_COUNT_SELECT 3
`define CHG_POS_VCELL 0
`define CHG_POS_LOW2 6
`define CHG_POS_FD 0
`define CHG_POS_IBATR 4
`define CHG_POS_IBUSR 2
`define CHG_POS_VBATMON 1
`define CHG_POS_VBUSR 0
`define CHG_POS_OTG 7
`define CHG_POS_VINR 4
`define CHG_POS_FB 4

// Bus current ratio codes that the host may not write
`define CHG_IBUSR_BAD_LO 2'b00
`define CHG_IBUSR_BAD_HI 2'b11

`endif

// [chg_pkg.sv]
package chg_pkg;

  typedef enum logic [2:0] {
    CHG_ST_IDLE = 3'b000,
    CHG_ST_ADDR = 3'b001,
    CHG_ST_ADDR_ACK = 3'b010,
    CHG_ST_WDATA = 3'b011,
    CHG_ST_WACK = 3'b100,
    CHG_ST_RDATA = 3'b101,
    CHG_ST_RACK = 3'b110
  } chg_state_e;

  typedef logic [9:0] chg_code_t;

  typedef struct packed {
    logic scl_meta;
    logic scl_sync;
    logic scl_prev;
    logic sda_meta;
    logic sda_sync;
    logic sda_prev;
  } chg_sync_s;

  typedef struct packed {
    chg_state_e st;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic rnw;
    logic first;
    logic nack;
    logic drive_low;
    logic [15:0][7:0] rw;
  } chg_main_s;

endpackage : chg_pkg

// [chg_line_if.sv]
`timescale 1ns/1ns
interface chg_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  modport src (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
  modport snk (input scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface : chg_line_if

// [chg_pin_sync.sv]
`timescale 1ns/1ns
module chg_pin_sync (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Serial pins
  input wire logic scl_i,
  input wire logic sda_i,
  // Conditioned line events
  chg_line_if.src line
);
  import chg_pkg::*;

  localparam chg_sync_s RST = '{default: 1'b1};

  chg_sync_s q;
  chg_sync_s d;

  always_comb begin
    d = q;
    if (ce_i) begin
      d.scl_meta = scl_i;
      d.scl_sync = q.scl_meta;
      d.scl_prev = q.scl_sync;
      d.sda_meta = sda_i;
      d.sda_sync = q.sda_meta;
      d.sda_prev = q.sda_sync;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // Edges and bus conditions look only at the second stage onward
  assign line.scl = q.scl_sync;
  assign line.sda = q.sda_sync;
  assign line.scl_rise = q.scl_sync & ~q.scl_prev;
  assign line.scl_fall = ~q.scl_sync & q.scl_prev;
  assign line.start_det = q.scl_sync & q.scl_prev & q.sda_prev & ~q.sda_sync;
  assign line.stop_det = q.scl_sync & q.scl_prev & ~q.sda_prev & q.sda_sync;

endmodule : chg_pin_sync

// [chg_host_model.sv]
`timescale 1ns/1ns
module chg_host_model (
  // Clock
  input wire logic core_clk_i,
  // Serial lines
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // ************************************
  // Line timing: each SCL level lasts four core clocks
  // ************************************
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : wt

  task automatic bit_io(input logic b, output logic r);
    wt(2);
    sda_low_o <= ~b;
    wt(2);
    scl_o <= 1'b1;
    wt(2);
    @(negedge core_clk_i);
    r = sda_i;
    wt(2);
    scl_o <= 1'b0;
  endtask : bit_io

  task automatic start_cond;
    wt(2);
    sda_low_o <= 1'b0;
    wt(2);
    scl_o <= 1'b1;
    wt(2);
    sda_low_o <= 1'b1;
    wt(2);
    scl_o <= 1'b0;
  endtask : start_cond

  task automatic stop_cond;
    wt(2);
    sda_low_o <= 1'b1;
    wt(2);
    scl_o <= 1'b1;
    wt(2);
    sda_low_o <= 1'b0;
    wt(4);
  endtask : stop_cond

  // Ninth bit: host drives ack_bit and returns what the wire showed
  task automatic byte_io(input logic [7:0] d, input logic ack_bit, output logic [7:0] q,
                         output logic nine);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_bit, nine);
  endtask : byte_io

  // Writes two bytes from pointer p onwards
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d,
                    output logic [2:0] nk);
    logic [7:0] q;
    logic dm;
    start_cond;
    byte_io({a, 1'b0}, 1'b1, q, nk[2]);
    byte_io(p, 1'b1, q, nk[1]);
    byte_io(d[15:8], 1'b1, q, nk[0]);
    byte_io(d[7:0], 1'b1, q, dm);
    stop_cond;
  endtask : wr

  // Reads two bytes from pointer p onwards, ACK then NACK
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [15:0] q,
                    output logic [2:0] nk);
    logic [7:0] q0;
    logic dm;
    start_cond;
    byte_io({a, 1'b0}, 1'b1, q0, nk[2]);
    byte_io(p, 1'b1, q0, nk[1]);
    start_cond;
    byte_io({a, 1'b1}, 1'b1, q0, nk[0]);
    byte_io(8'hff, 1'b0, q[15:8], dm);
    byte_io(8'hff, 1'b1, q[7:0], dm);
    stop_cond;
  endtask : rd
endmodule : chg_host_model

// [chg_config_bank_tb.sv]
`timescale 1ns/1ns
`define CHK_EQ(g, e) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); \
  end \
end
module chg_config_bank_tb;
  import chg_pkg::*;
  localparam logic [6:0] DEV = 7'h2a;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  chg_code_t bvr = 10'h2d7;
  chg_code_t bar = 10'h16b;
  chg_code_t bir = 10'h0fe;
  chg_code_t btr = 10'h301;
  logic [6:0] sts = 7'h55;
  logic scl, hl, sd_o, sd_oe_n;
  wire sda_w;
  logic [1:0] irc, fdl, bcs;
  logic [2:0] ccs, pcv;
  chg_code_t iref, eref, aref;
  logic [7:0] bcl, btl, irg, c0, c1, c2, c3, msk, dlc, dlr;
  logic irs, bts, bms, bvs, dds, fss;
  logic [7:0] sh [0:31];
  int errors = 0;
  int num_checks = 0;

  always #50 clk = ~clk;
  // Open-drain wire with pull-up
  assign sda_w = (sd_oe_n ? 1'b1 : sd_o) & ~hl;

  chg_config_bank #(.DEV_ADDR(DEV)) dut (
    .core_clk_i(clk), .reset_i(rst), .ce_i(ce), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sd_o), .sda_oe_n_o(sd_oe_n), .bus_v_result_i(bvr), .bat_v_result_i(bar),
    .bus_i_result_i(bir), .bat_i_result_i(btr), .status_i(sts),
    .ir_compensation_o(irc), .cell_count_select_o(ccs), .per_cell_voltage_o(pcv),
    .internal_ref_code_o(iref), .external_ref_code_o(eref), .active_ref_code_o(aref),
    .fast_discharge_level_o(fdl), .bus_current_limit_code_o(bcl),
    .battery_current_limit_code_o(btl), .input_regulation_code_o(irg),
    .input_regulation_scale_o(irs), .battery_current_scale_o(bts),
    .bus_current_scale_o(bcs), .battery_monitor_scale_o(bms), .bus_voltage_scale_o(bvs),
    .discharge_direction_select_o(dds), .feedback_source_select_o(fss),
    .control_zero_o(c0), .control_one_o(c1), .control_two_o(c2), .control_three_o(c3),
    .event_mask_o(msk), .data_line_control_o(dlc), .data_line_readback_o(dlr)
  );

  chg_host_model host (.core_clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_low_o(hl));

  // ************************************
  // Expected-value model
  // ************************************
  task automatic rst_shadow;
    sh = '{0: 8'h01, 1: 8'h31, 2: 8'hc0, 3: 8'h7c, 4: 8'hc0, 5: 8'hff, 6: 8'hff,
           7: 8'h2c, 8: 8'h38, 9: 8'h04, 10: 8'h01, 11: 8'h01, 12: 8'h02, 25: 8'h80,
           default: 8'h00};
  endtask : rst_shadow

  function automatic logic [7:0] rsv(input logic [7:0] p);
    case (p)
      8'h08: return 8'he0;
      8'h09: return 8'h60;
      8'h0a: return 8'h03;
      8'h0b: return 8'hc8;
      8'h19: return 8'h01;
      default: return 8'h00;
    endcase
  endfunction : rsv

  function automatic logic [7:0] exp_rd(input logic [7:0] p);
    case (p)
      8'h0d: return bvr[9:2];
      8'h0e: return {bvr[1:0], 6'h00};
      8'h0f: return bar[9:2];
      8'h10: return {bar[1:0], 6'h00};
      8'h11: return bir[9:2];
      8'h12: return {bir[1:0], 6'h00};
      8'h13: return btr[9:2];
      8'h14: return {btr[1:0], 6'h00};
      8'h17: return {sts, 1'b0};
      default: return (p < 8'h20) ? sh[p[4:0]] : 8'h00;
    endcase
  endfunction : exp_rd

  task automatic check_outs;
    `CHK_EQ({irc, ccs, pcv}, sh[0])
    `CHK_EQ(iref, {sh[1], sh[2][7:6]})
    `CHK_EQ(eref, {sh[3], sh[4][7:6]})
    `CHK_EQ(aref, sh[10][4] ? {sh[3], sh[4][7:6]} : {sh[1], sh[2][7:6]})
    `CHK_EQ(fdl, sh[9][7] ? sh[2][1:0] : 2'b00)
    `CHK_EQ({bcl, btl, irg}, {sh[5], sh[6], sh[7]})
    `CHK_EQ({irs, dds, fss}, {sh[9][4], sh[9][7], sh[10][4]})
    `CHK_EQ({bts, bcs, bms, bvs}, sh[8][4:0])
    `CHK_EQ({c0, c1, c2, c3}, {sh[9], sh[10], sh[11], sh[12]})
    `CHK_EQ({msk, dlc, dlr}, {sh[25], sh[26], sh[27]})
    `CHK_EQ({sd_o, sd_oe_n}, 2'b01)
  endtask : check_outs

  // ************************************
  // Access tasks
  // ************************************
  task automatic wr_pair(input logic [7:0] p, input logic [15:0] d);
    logic [2:0] nk;
    logic [7:0] q;
    logic [7:0] b;
    logic [15:0] v;
    for (int j = 0; j < 2; j++) begin
      q = p + 8'(j);
      b = d[15 - 8 * j -: 8];
      b = (b & ~rsv(q)) | (sh[q[4:0]] & rsv(q));
      v[15 - 8 * j -: 8] = b;
      if (q == 8'h08 && (b[3:2] == 2'b00 || b[3:2] == 2'b11)) begin
        b[3:2] = sh[8][3:2];
      end
      if (q < 8'h0d || (q > 8'h18 && q < 8'h1c)) begin
        sh[q[4:0]] = b;
      end
    end
    host.wr(DEV, p, v, nk);
    `CHK_EQ(nk, 3'b000)
    check_outs;
  endtask : wr_pair

  task automatic read_all;
    logic [15:0] q;
    logic [2:0] nk;
    for (int p = 0; p < 30; p += 2) begin
      host.rd(DEV, 8'(p), q, nk);
      `CHK_EQ(nk, 3'b000)
      `CHK_EQ(q[15:8], exp_rd(8'(p)))
      `CHK_EQ(q[7:0], exp_rd(8'(p + 1)))
    end
  endtask : read_all

  task automatic wrap_up;
    if (errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  // ************************************
  // Test sequence
  // ************************************
  initial begin
    logic [2:0] nk;
    logic [7:0] k;
    rst_shadow;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    check_outs;
    read_all;
    for (int i = 0; i < 2; i++) begin
      k = i ? 8'h4a : 8'hb5;
      for (int p = 0; p < 28; p += 2) begin
        wr_pair(8'(p), {k ^ 8'(p), k ^ 8'(p + 1)});
      end
      read_all;
    end
    wr_pair(8'h01, 16'hffc2);
    wr_pair(8'h08, 16'h2c80);
    wr_pair(8'h08, 16'h3080);
    wr_pair(8'h08, 16'h3700);
    host.wr(7'h2b, 8'h07, 16'h1234, nk);
    `CHK_EQ(nk, 3'b111)
    check_outs;
    // Clock enable low freezes the port: no acknowledge and no write
    ce <= 1'b0;
    host.wr(DEV, 8'h07, 16'h1234, nk);
    ce <= 1'b1;
    `CHK_EQ(nk, 3'b111)
    check_outs;
    @(posedge clk);
    bvr <= 10'h0c3;
    bar <= 10'h3fe;
    bir <= 10'h001;
    btr <= 10'h282;
    sts <= 7'h2a;
    read_all;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rst_shadow;
    repeat (5) @(posedge clk);
    check_outs;
    read_all;
    wrap_up;
  end

  initial begin
    #8_000_000;
    errors++;
    wrap_up;
  end
endmodule : chg_config_bank_tb
